/* File: rtl/pbpc_pin.sv */
// One multiplexed pin: picks GPIO or alternate drive, registered.
// Assumes the select inputs are decoded synchronously to hclk.
`timescale 1ns/1ps
module pbpc_pin (
  input  wire logic hclk,     // Bus clock
  input  wire logic hresetn,  // Async reset, low
  input  wire logic ce,       // Clock enable
  input  wire logic gpio_sel, // Pin is general I/O
  input  wire logic dir,      // GPIO direction, 1 = out
  input  wire logic dout,     // GPIO output data
  input  wire logic alt_oe,   // Alternate function drives
  input  wire logic alt_val,  // Alternate output level
  output logic      pin_out,  // Pin output level
  output logic      pin_oe    // Pin output enable, high drives
);

  // ----------------------------------------------------------------
  // Output driver
  // ----------------------------------------------------------------
  // Direction only counts in GPIO mode; otherwise alt decides
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (ce) begin
      if (gpio_sel) begin
        pin_out <= dout;
        pin_oe  <= dir;
      end else begin
        pin_out <= alt_val;
        pin_oe  <= alt_oe;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gpio_dir_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && gpio_sel |=> pin_oe == $past(dir)
      && (!$past(dir) || pin_out == $past(dout)))
    else $error("gpio pin drive does not follow direction");

endmodule : pbpc_pin

/* File: rtl/pbpc_pkg.sv */
// Constants for the port B / port C pin function select block.
// Assumes an AHB-Lite bus with 32-bit data and word-only accesses.
package pbpc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets inside the block window
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_PB_UPPER = 4'h0; // Port B pins 9..8
  localparam logic [3:0] OFS_PB_LOWER = 4'h4; // Port B pins 7..0
  localparam logic [3:0] OFS_PC_DIR   = 4'h8; // Port C direction
  localparam logic [3:0] OFS_PC_FUNC  = 4'hC; // Port C function
  localparam int unsigned WIN_MSB     = 11;   // Window is 4 KiB

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PB_UPPER  = 16'h0000;
  localparam logic [15:0] RST_PB_LOWER  = 16'h0000;
  localparam logic [15:0] RST_PC_DIR    = 16'h0000;
  localparam logic [15:0] RST_PC_FUNC   = 16'h0000;
  localparam logic [15:0] MASK_PB_UPPER = 16'h000F; // 15..4 reserved
  localparam logic [15:0] MASK_PB_LOWER = 16'hFFF5; // 3 and 1 reserved
  localparam logic [15:0] MASK_PC       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Field positions (low bit of each select field)
  // ----------------------------------------------------------------
  localparam int unsigned PB9_LSB = 2;  // Upper register
  localparam int unsigned PB8_LSB = 0;  // Upper register
  localparam int unsigned PB7_LSB = 14; // Lower register
  localparam int unsigned PB6_LSB = 12;
  localparam int unsigned PB5_LSB = 10;
  localparam int unsigned PB4_LSB = 8;
  localparam int unsigned PB3_LSB = 6;
  localparam int unsigned PB2_LSB = 4;
  localparam int unsigned PB1_BIT = 2;
  localparam int unsigned PB0_BIT = 0;

  // ----------------------------------------------------------------
  // Two-bit function codes and idle levels
  // ----------------------------------------------------------------
  localparam logic [1:0] FN_GPIO = 2'h0; // General I/O
  localparam logic [1:0] FN_IRQ  = 2'h1; // Interrupt request input
  localparam logic [1:0] FN_ALT1 = 2'h2; // Address / enable input
  localparam logic [1:0] FN_ALT2 = 2'h3; // Bus handshake / strobe
  localparam logic       IN_IDLE = 1'h1; // Unrouted peripheral input

endpackage : pbpc_pkg

/* File: rtl/pbpc_top.sv */
// Port B / port C pin function select with an AHB-Lite slave.
// Assumes one slave on the bus; hresetn is the power-on reset.
`timescale 1ns/1ps
module pbpc_top (
  input  wire logic        hclk,             // Bus clock
  input  wire logic        hresetn,          // Power-on reset, low
  input  wire logic        ce,               // Clock enable
  input  wire logic        hsel,             // Slave select
  input  wire logic [31:0] haddr,            // Byte address
  input  wire logic [1:0]  htrans,           // Transfer type
  input  wire logic        hwrite,           // Write strobe
  input  wire logic [2:0]  hsize,            // Size, word only
  input  wire logic [31:0] hwdata,           // Write data
  input  wire logic        hready,           // Bus ready
  output logic             hreadyout,        // Slave ready
  output logic             hresp,            // Always OKAY
  output logic [31:0]      hrdata,           // Read data
  input  wire logic        mode_single_chip, // Single chip mode
  input  wire logic        mode_rom_off,     // On-chip ROM off
  input  wire logic [9:0]  pb_in,            // Port B pin levels
  output logic [9:0]       pb_out,           // Port B pin drive
  output logic [9:0]       pb_oe,            // Port B enables
  input  wire logic [15:0] pc_in,            // Port C pin levels
  output logic [15:0]      pc_out,           // Port C pin drive
  output logic [15:0]      pc_oe,            // Port C enables
  input  wire logic [9:0]  gpio_b_dir,       // Port B direction
  input  wire logic [9:0]  gpio_b_dout,      // Port B GPIO data
  output logic [9:0]       gpio_b_din,       // Port B GPIO read
  input  wire logic [15:0] gpio_c_dout,      // Port C GPIO data
  output logic [15:0]      gpio_c_din,       // Port C GPIO read
  input  wire logic [21:0] addr_in,          // Bus address lines
  input  wire logic        bus_ack_out,      // Bus acknowledge
  input  wire logic        read_write_out,   // Bus read/write
  input  wire logic        upper_column_strobe, // Upper CAS
  input  wire logic        lower_column_strobe, // Lower CAS
  input  wire logic        row_strobe,       // Row strobe
  output logic [7:0]       interrupt_request_in, // To irq ctl
  output logic [3:0]       output_enable_in, // To timer
  output logic             conversion_trigger_in, // To ADC
  output logic             wait_request_in,  // To bus ctl
  output logic             bus_request_in    // To bus ctl
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] ub_r, ub_nxt;       // Upper B function select
  logic [15:0] lb_r, lb_nxt;       // Lower B function select
  logic [15:0] pc_dir_r, pc_dir_nxt; // Port C direction
  logic [15:0] pc_fn_r, pc_fn_nxt; // Port C function select
  logic        wr_pend_r;          // Write data phase pending
  logic [3:0]  wr_ofs_r;           // Offset of pending write
  logic        ap_hit;             // Address inside window
  logic        ap_go;              // Address phase accepted
  logic        ap_rd;              // Accepted read
  logic [15:0] rd_val;             // Read mux result
  logic [1:0]  fsel [2:9];         // Port B two-bit fields
  logic [9:0]  b_gpio, b_aoe, b_aval; // Port B decode
  logic [15:0] c_alt;              // Port C address mode
  logic [7:0]  irq_sel;            // Interrupt routing
  logic [3:0]  poe_sel;            // Enable input routing
  logic        trg_sel, wait_sel, bus_request_in_sel; // Handshake routing
  logic [25:0] p_out, p_oe;        // Pin cell outputs

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Only NONSEQ/SEQ with hready take part; IDLE/BUSY do nothing
  assign ap_hit = (haddr[pbpc_pkg::WIN_MSB:4] == '0);
  assign ap_go  = hsel && hready && htrans[1];
  assign ap_rd  = ap_go && !hwrite;

  // Remember a write so the data phase can land it next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 4'h0;
    end else if (ce) begin
      wr_pend_r <= ap_go && hwrite && ap_hit;
      wr_ofs_r  <= haddr[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Reserved bits are masked off so they always read zero;
  // misaligned offsets fall to default and are dropped
  always_comb begin
    ub_nxt     = ub_r;
    lb_nxt     = lb_r;
    pc_dir_nxt = pc_dir_r;
    pc_fn_nxt  = pc_fn_r;
    if (wr_pend_r) begin
      case (wr_ofs_r)
        pbpc_pkg::OFS_PB_UPPER: begin
          ub_nxt = hwdata[15:0] & pbpc_pkg::MASK_PB_UPPER;
        end
        pbpc_pkg::OFS_PB_LOWER: begin
          lb_nxt = hwdata[15:0] & pbpc_pkg::MASK_PB_LOWER;
        end
        pbpc_pkg::OFS_PC_DIR: begin
          pc_dir_nxt = hwdata[15:0] & pbpc_pkg::MASK_PC;
        end
        pbpc_pkg::OFS_PC_FUNC: begin
          pc_fn_nxt = hwdata[15:0] & pbpc_pkg::MASK_PC;
        end
        default: begin
          ub_nxt = ub_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only power-on reset clears them; there is no soft reset input,
  // so manual, watchdog and sleep states leave them untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ub_r     <= pbpc_pkg::RST_PB_UPPER;
      lb_r     <= pbpc_pkg::RST_PB_LOWER;
      pc_dir_r <= pbpc_pkg::RST_PC_DIR;
      pc_fn_r  <= pbpc_pkg::RST_PC_FUNC;
    end else if (ce) begin
      ub_r     <= ub_nxt;
      lb_r     <= lb_nxt;
      pc_dir_r <= pc_dir_nxt;
      pc_fn_r  <= pc_fn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reads use next values so a read right after a write sees it
  always_comb begin
    case (haddr[3:0])
      pbpc_pkg::OFS_PB_UPPER: rd_val = ub_nxt;
      pbpc_pkg::OFS_PB_LOWER: rd_val = lb_nxt;
      pbpc_pkg::OFS_PC_DIR:   rd_val = pc_dir_nxt;
      pbpc_pkg::OFS_PC_FUNC:  rd_val = pc_fn_nxt;
      default:                rd_val = 16'h0000;
    endcase
    if (!ap_hit) begin
      rd_val = 16'h0000;
    end
  end

  // Read data held through the data phase; upper half is zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && ap_rd) begin
      hrdata <= {16'h0000, rd_val};
    end
  end

  // Zero wait states and OKAY always, so both are constant flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Port B function decode
  // ----------------------------------------------------------------
  assign fsel[9] = ub_r[pbpc_pkg::PB9_LSB +: 2];
  assign fsel[8] = ub_r[pbpc_pkg::PB8_LSB +: 2];
  assign fsel[7] = lb_r[pbpc_pkg::PB7_LSB +: 2];
  assign fsel[6] = lb_r[pbpc_pkg::PB6_LSB +: 2];
  assign fsel[5] = lb_r[pbpc_pkg::PB5_LSB +: 2];
  assign fsel[4] = lb_r[pbpc_pkg::PB4_LSB +: 2];
  assign fsel[3] = lb_r[pbpc_pkg::PB3_LSB +: 2];
  assign fsel[2] = lb_r[pbpc_pkg::PB2_LSB +: 2];

  // Single chip mode turns bus functions, except read/write on pin 5, back into GPIO
  always_comb begin
    b_gpio   = '1;
    b_aoe    = '0;
    b_aval   = '0;
    irq_sel  = '0;
    poe_sel  = '0;
    trg_sel  = 1'b0;
    wait_sel = 1'b0;
    bus_request_in_sel = 1'b0;
    // Interrupt code is common to pins 2..9
    for (int i = 2; i < 10; i++) begin
      if (fsel[i] == pbpc_pkg::FN_IRQ) begin
        b_gpio[i]    = 1'b0;
        irq_sel[i-2] = 1'b1;
      end
    end
    // Address lines 18..21 on pins 6..9
    for (int i = 6; i < 10; i++) begin
      if (fsel[i] == pbpc_pkg::FN_ALT1 && !mode_single_chip) begin
        b_gpio[i] = 1'b0;
        b_aoe[i]  = 1'b1;
        b_aval[i] = addr_in[12+i];
      end
    end
    // Output enable inputs on pins 2..5
    for (int i = 2; i < 6; i++) begin
      if (fsel[i] == pbpc_pkg::FN_ALT1) begin
        b_gpio[i]    = 1'b0;
        poe_sel[i-2] = 1'b1;
      end
    end
    if (fsel[9] == pbpc_pkg::FN_ALT2) begin
      b_gpio[9] = 1'b0;
      trg_sel   = 1'b1;
    end
    if (fsel[8] == pbpc_pkg::FN_ALT2 && !mode_single_chip) begin
      b_gpio[8] = 1'b0;
      wait_sel  = 1'b1;
    end
    if (fsel[7] == pbpc_pkg::FN_ALT2 && !mode_single_chip) begin
      b_gpio[7] = 1'b0;
      bus_request_in_sel  = 1'b1;
    end
    if (fsel[6] == pbpc_pkg::FN_ALT2 && !mode_single_chip) begin
      b_gpio[6] = 1'b0;
      b_aoe[6]  = 1'b1;
      b_aval[6] = bus_ack_out;
    end
    // Read/write output has no single chip fallback
    if (fsel[5] == pbpc_pkg::FN_ALT2) begin
      b_gpio[5] = 1'b0;
      b_aoe[5]  = 1'b1;
      b_aval[5] = read_write_out;
    end
    if (fsel[4] == pbpc_pkg::FN_ALT2 && !mode_single_chip) begin
      b_gpio[4] = 1'b0;
      b_aoe[4]  = 1'b1;
      b_aval[4] = upper_column_strobe;
    end
    if (fsel[3] == pbpc_pkg::FN_ALT2 && !mode_single_chip) begin
      b_gpio[3] = 1'b0;
      b_aoe[3]  = 1'b1;
      b_aval[3] = lower_column_strobe;
    end
    if (fsel[2] == pbpc_pkg::FN_ALT2 && !mode_single_chip) begin
      b_gpio[2] = 1'b0;
      b_aoe[2]  = 1'b1;
      b_aval[2] = row_strobe;
    end
    // ROM-off mode forces address out even with the bit clear
    if (!mode_single_chip
        && (lb_r[pbpc_pkg::PB1_BIT] || mode_rom_off)) begin
      b_gpio[1] = 1'b0;
      b_aoe[1]  = 1'b1;
      b_aval[1] = addr_in[17];
    end
    if (!mode_single_chip
        && (lb_r[pbpc_pkg::PB0_BIT] || mode_rom_off)) begin
      b_gpio[0] = 1'b0;
      b_aoe[0]  = 1'b1;
      b_aval[0] = addr_in[16];
    end
  end

  // ----------------------------------------------------------------
  // Port C function decode
  // ----------------------------------------------------------------
  // Bit set, or ROM off, gives address line n unless single chip
  assign c_alt = mode_single_chip ? 16'h0000
               : (pc_fn_r | {16{mode_rom_off}});

  // ----------------------------------------------------------------
  // Pin cells, port B in 9..0 and port C in 25..10
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 26; g++) begin : g_pin
    pbpc_pin u_pin (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .gpio_sel ({~c_alt, b_gpio}[g]),
      .dir      ({pc_dir_r, gpio_b_dir}[g]),
      .dout     ({gpio_c_dout, gpio_b_dout}[g]),
      .alt_oe   ({c_alt, b_aoe}[g]),
      .alt_val  ({addr_in[15:0], b_aval}[g]),
      .pin_out  (p_out[g]),
      .pin_oe   (p_oe[g])
    );
  end

  assign pb_out = p_out[9:0];
  assign pb_oe  = p_oe[9:0];
  assign pc_out = p_out[25:10];
  assign pc_oe  = p_oe[25:10];

  // ----------------------------------------------------------------
  // Input routing to peripherals
  // ----------------------------------------------------------------
  // Unselected peripherals see the idle level, so a pin used as
  // GPIO can never fake an interrupt or a bus request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_request_in  <= {8{pbpc_pkg::IN_IDLE}};
      output_enable_in      <= {4{pbpc_pkg::IN_IDLE}};
      conversion_trigger_in <= pbpc_pkg::IN_IDLE;
      wait_request_in       <= pbpc_pkg::IN_IDLE;
      bus_request_in        <= pbpc_pkg::IN_IDLE;
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        interrupt_request_in[i] <=
          irq_sel[i] ? pb_in[i+2] : pbpc_pkg::IN_IDLE;
      end
      for (int i = 0; i < 4; i++) begin
        output_enable_in[i] <=
          poe_sel[i] ? pb_in[i+2] : pbpc_pkg::IN_IDLE;
      end
      conversion_trigger_in <= trg_sel ? pb_in[9] : pbpc_pkg::IN_IDLE;
      wait_request_in  <= wait_sel ? pb_in[8] : pbpc_pkg::IN_IDLE;
      bus_request_in   <= bus_request_in_sel ? pb_in[7] : pbpc_pkg::IN_IDLE;
    end
  end

  // GPIO read path samples the pin levels every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_b_din <= 10'h000;
      gpio_c_din <= 16'h0000;
    end else if (ce) begin
      gpio_b_din <= pb_in;
      gpio_c_din <= pc_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  up_rsvd_a: assert property (
    ce && ap_rd && ap_hit && haddr[3:0] == pbpc_pkg::OFS_PB_UPPER
    |=> hrdata[31:4] == '0)
    else $error("upper select reserved bits not zero");

  trig_route_a: assert property (
    ce && ub_r[3:2] == pbpc_pkg::FN_ALT2
    |=> conversion_trigger_in == $past(pb_in[9]) && !pb_oe[9])
    else $error("trigger input not routed from pin 9");

  wait_sc_a: assert property (
    ce && ub_r[1:0] == pbpc_pkg::FN_ALT2 && mode_single_chip
    |=> wait_request_in == pbpc_pkg::IN_IDLE
      && pb_oe[8] == $past(gpio_b_dir[8]))
    else $error("pin 8 not general I/O in single chip");

  bus_request_in_route_a: assert property (
    ce && lb_r[15:14] == pbpc_pkg::FN_ALT2 && !mode_single_chip
    |=> bus_request_in == $past(pb_in[7]))
    else $error("bus request not routed from pin 7");

  addr18_drive_a: assert property (
    ce && lb_r[13:12] == pbpc_pkg::FN_ALT1 && !mode_single_chip
    |=> pb_oe[6] && pb_out[6] == $past(addr_in[18]))
    else $error("pin 6 does not drive address 18");

  read_write_out_drive_a: assert property (
    ce && lb_r[11:10] == pbpc_pkg::FN_ALT2
    |=> pb_oe[5] && pb_out[5] == $past(read_write_out))
    else $error("pin 5 does not drive read/write");

  poe2_route_a: assert property (
    ce && lb_r[9:8] == pbpc_pkg::FN_ALT1
    |=> output_enable_in[2] == $past(pb_in[4]) && !pb_oe[4])
    else $error("enable input 2 not routed from pin 4");

  lo_rsvd_a: assert property (
    ce && ap_rd && ap_hit && haddr[3:0] == pbpc_pkg::OFS_PB_LOWER
    |=> !hrdata[3] && !hrdata[1] && hrdata[31:16] == '0)
    else $error("lower select reserved bits not zero");

  addr17_drive_a: assert property (
    ce && !mode_single_chip && (lb_r[2] || mode_rom_off)
    |=> pb_oe[1] && pb_out[1] == $past(addr_in[17]))
    else $error("pin 1 does not drive address 17");

  pc_wback_a: assert property (
    ce && wr_pend_r && wr_ofs_r == pbpc_pkg::OFS_PC_DIR
    |=> pc_dir_r == $past(hwdata[15:0]))
    else $error("direction write not stored");

  pc_addr_a: assert property (
    ce && pc_fn_r[5] && !mode_single_chip
    |=> pc_oe[5] && pc_out[5] == $past(addr_in[5]))
    else $error("port C pin 5 does not drive address 5");

  trig_cov_c: cover property (
    ce && ub_r[3:2] == pbpc_pkg::FN_ALT2 ##1 conversion_trigger_in);
  pc_addr_c: cover property (ce && c_alt == 16'hFFFF);
  wr_rd_c: cover property (
    ce && wr_pend_r ##0 ap_rd ##1 hrdata != '0);

endmodule : pbpc_top

/* File: sim/test_port_b_c_pin_function_select.sv */
// Self-checking bench for the port B / port C pin function select block.
// Assumes pbpc_top is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module test_port_b_c_pin_function_select;
  logic        hclk, hresetn, hwrite, hreadyout, chk;
  logic        mode_single_chip, mode_rom_off, bus_ack_out, read_write_out;
  logic        upper_column_strobe, lower_column_strobe, row_strobe;
  logic        conversion_trigger_in, wait_request_in, bus_request_in;
  logic [1:0]  htrans;
  logic [9:0]  pb_in, pb_out, pb_oe, gpio_b_dir, gpio_b_dout;
  logic [15:0] pc_in, pc_out, pc_oe, gpio_c_dout, d, f;
  logic [21:0] addr_in;
  logic [7:0]  interrupt_request_in;
  logic [3:0]  output_enable_in;
  logic [31:0] haddr, hwdata, hrdata, st, s;
  logic [33:0] e;
  logic [33:0] q[$];   // Expected notes: kind, value
  int          err_total, n_tests;
  logic [31:0] msk [5] = '{32'hF, 32'hFFF5, 32'hFFFF, 32'hFFFF, 32'h0};
  string       nm [4] = '{"hrdata", "port_b", "port_c", "inputs"};

  pbpc_top i_dut (.hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp(), .hrdata, .mode_single_chip, .mode_rom_off, .pb_in, .pb_out,
    .pb_oe, .pc_in, .pc_out, .pc_oe, .gpio_b_dir, .gpio_b_dout,
    .gpio_b_din(), .gpio_c_dout, .gpio_c_din(), .addr_in, .bus_ack_out,
    .read_write_out, .upper_column_strobe, .lower_column_strobe, .row_strobe,
    .interrupt_request_in, .output_enable_in, .conversion_trigger_in,
    .wait_request_in, .bus_request_in);

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Xorshift source, fixed start so every run repeats
  function automatic logic [31:0] nx();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : nx

  task automatic stir();
    {gpio_b_dir, gpio_b_dout, pb_in} <= 30'(nx());
    {gpio_c_dout, pc_in} <= nx();
    {addr_in, bus_ack_out, read_write_out, upper_column_strobe,
     lower_column_strobe, row_strobe} <= 27'(nx());
  endtask : stir

  // One AHB single transfer; for a read, dt is the expected word
  task automatic bus(input logic w, input logic [31:0] a, dt);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dt;
    if (!w) begin
      q.push_back({2'h0, dt});
      chk <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk <= 1'b0;
  endtask : bus

  // Pin flops follow one cycle after the register edge
  task automatic pin(input logic [1:0] k, input logic [31:0] x);
    @(posedge hclk);
    q.push_back({k, x});
    chk <= 1'b1;
    @(posedge hclk);
    chk <= 1'b0;
  endtask : pin

  // Port B drive: {oe, out masked by oe}
  function automatic logic [31:0] pbx(input logic [1:0] c);
    logic [9:0] o, en;
    logic [4:0] s3;
    logic [1:0] k;
    s3 = {bus_ack_out, read_write_out, upper_column_strobe,
          lower_column_strobe, row_strobe};
    for (int p = 0; p < 10; p++) begin
      k = (p < 2) ? {c[1], 1'b0} : c;
      if (mode_single_chip && k[1] && p != 5 && !(p == 9 && k == 2'h3)) k = 0;
      o[p]  = gpio_b_dout[p];
      en[p] = gpio_b_dir[p];
      if (k == 2'h1 || (k == 2'h2 && p > 1 && p < 6) || (k == 2'h3 && p > 6))
        en[p] = 1'b0;
      else if (k == 2'h2) begin
        o[p]  = addr_in[p < 2 ? p + 16 : p + 12];
        en[p] = 1'b1;
      end else if (k == 2'h3) begin
        o[p]  = s3[p - 2];
        en[p] = 1'b1;
      end
    end
    return {12'h0, en, o & en};
  endfunction : pbx

  // Routed peripheral inputs idle high when not selected
  function automatic logic [31:0] inx(input logic [1:0] c);
    logic w;
    w = c == 2'h3 && !mode_single_chip;
    return {17'h0, c == 2'h1 ? pb_in[9:2] : 8'hFF,
            c == 2'h2 ? pb_in[5:2] : 4'hF, c == 2'h3 ? pb_in[9] : 1'b1,
            w ? pb_in[8] : 1'b1, w ? pb_in[7] : 1'b1};
  endfunction : inx

  function automatic logic [31:0] pcx(input logic [15:0] dr, fs);
    logic [15:0] a;
    a = mode_single_chip ? 16'h0 : (mode_rom_off ? 16'hFFFF : fs);
    return {a | dr, ((addr_in[15:0] & a) | (gpio_c_dout & ~a)) & (a | dr)};
  endfunction : pcx

  // Monitor: oldest note against what the outputs show
  always @(posedge hclk) begin
    if (chk === 1'b1) begin
      e = q.pop_front();
      case (e[33:32])
        2'h0:    s = hrdata;
        2'h1:    s = {12'h0, pb_oe, pb_out & pb_oe};
        2'h2:    s = {pc_oe, pc_out & pc_oe};
        default: s = {17'h0, interrupt_request_in, output_enable_in,
                      conversion_trigger_in, wait_request_in, bus_request_in};
      endcase
      n_tests++;
      if (s !== e[31:0]) begin
        err_total++;
        $display("unexpected %s exp %h got %h", nm[e[33:32]], e[31:0], s);
      end
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic zeros();
    for (int i = 0; i < 4; i++) bus(1'b0, 32'(4 * i), 32'h0);
    $display("test reset_values done");
  endtask : zeros

  initial begin
    st = 32'h45AA; chk = 0; hresetn = 0; htrans = 0; hwrite = 0; haddr = 0;
    hwdata = 0; mode_single_chip = 0; mode_rom_off = 0; stir();
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    zeros();
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 32'(4 * i), 32'hFFFFFFFF);
      bus(1'b0, 32'(4 * i), msk[i]);
    end
    $display("test reserved_bits done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        mode_single_chip <= m[0];
        stir();
        bus(1'b1, 32'h0, {28'h0, c[1:0], c[1:0]});
        bus(1'b1, 32'h4, {16'h0, {6{c[1:0]}}, 1'b0, c[1], 1'b0, c[1]});
        pin(2'h1, pbx(c[1:0]));
        pin(2'h3, inx(c[1:0]));
      end
    end
    $display("test port_b_select done");
    for (int m = 0; m < 3; m++) begin
      stir();
      mode_single_chip <= m == 2;
      mode_rom_off     <= m == 1;
      d = 16'(nx());
      f = 16'(nx());
      bus(1'b1, 32'h8, {16'h0, d});
      bus(1'b1, 32'hC, {16'h0, f});
      pin(2'h2, pcx(d, f));
    end
    $display("test port_c_select done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    zeros();
    conclude();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : test_port_b_c_pin_function_select
